/* pic_router_defines.vh */
// constants for the interrupt router and cascaded legacy controller pair
`ifndef PIC_ROUTER_DEFINES_VH
`define PIC_ROUTER_DEFINES_VH

// command word kinds on cmd_kind_in
`define CMD_FIRST_OP      2'h0
`define CMD_SECOND_OP     2'h1
`define CMD_THIRD_OP      2'h2
`define CMD_FOURTH_INIT   2'h3

// second operation word: end-of-interrupt command field and level field
`define EOI_CMD_MSB       7
`define EOI_CMD_LSB       5
`define EOI_LVL_MSB       2
`define EOI_LVL_LSB       0
`define EOI_NONSPEC       3'h1
`define EOI_SPEC          3'h3
`define EOI_ROT_NONSPEC   3'h5
`define EOI_ROT_SPEC      3'h7

// third operation word fields
`define SPECIAL_MASK_WRITE_ENABLE_BIT          6
`define SMM_BIT           5

// fourth init word field
`define AUTO_END_OF_INTERRUPT_BIT          1

// reset values
`define MASK_RESET        16'h0000
`define ISR_RESET         16'h0000
`define SMM_RESET         2'h0
`define AUTO_END_OF_INTERRUPT_RESET        2'h0
`define ACK_IRQ_RESET     4'h0

// cascade input of the master and vector returned when a request vanished
`define CASCADE_BIT       2
`define DEFAULT_LEVEL     3'h7

// standby states in which both controllers are off
`define STANDBY_PARKED    2'h2
`define STANDBY_OSC_OFF   2'h3

// route control byte: bit 7 disables steering, bits 3:0 give the legacy input
`define ROUTE_DISABLE_BIT 7
`define ROUTE_IRQ_LSB     0
`define ROUTE_WIDTH       8
`define MAP_WIDTH         3

`endif

/* pic_eoi_router.v */
// interrupt decoder, pci line router and cascaded legacy controller end-of-interrupt and mask logic
`timescale 1ns/1ps
`include "pic_router_defines.vh"
module pic_eoi_router (
   // clock, reset and enable
   input  wire         mclk_in,
   input  wire         rstn_in,
   input  wire         ce_in,
   // command words from software
   input  wire         cmd_wr_in,
   input  wire         cmd_slave_in,
   input  wire [1:0]   cmd_kind_in,
   input  wire [7:0]   cmd_data_in,
   // configuration
   input  wire [15:0]  trigger_mode_select_in,
   input  wire [1:0]   standby_state_in,
   input  wire [383:0] device_pin_map_registers_in,
   input  wire [63:0]  pirq_route_in,
   // on-chip interrupt messages
   input  wire         msg_valid_in,
   input  wire         msg_legacy_in,
   input  wire         msg_assert_in,
   input  wire [4:0]   msg_dev_in,
   input  wire [1:0]   msg_pin_in,
   // serial irq controller sources
   input  wire [15:0]  serirq_irq_in,
   input  wire [3:0]   serirq_intx_n_in,
   // processor acknowledge
   input  wire         inta_in,
   output wire         intr_out,
   output reg          ack_valid_out,
   output reg  [3:0]   ack_irq_out,
   // status
   output wire [15:0]  in_service_bits_out,
   output wire [15:0]  channel_mask_register_out,
   output wire [1:0]   special_mask_out,
   output wire [7:0]   pci_interrupt_lines_out
);

   reg  [127:0] pin_state_reg;
   reg  [3:0]   legacy_reg;
   reg  [15:0]  imr_reg;
   reg  [15:0]  isr_reg;
   reg  [15:0]  edge_reg;
   reg  [15:0]  prev_reg;
   reg  [1:0]   smm_reg;
   reg  [1:0]   auto_end_of_interrupt_reg;
   reg  [7:0]   pirq_reg;

   reg  [7:0]   pirq_n;
   reg  [15:0]  routed;
   reg  [15:0]  lines;
   reg  [15:0]  isr_next;
   reg  [15:0]  edge_next;
   reg  [7:0]   cur;
   reg  [7:0]   cand;
   reg  [7:0]   clr;
   reg          ack_take;

   wire [15:0]  irr;
   wire [15:0]  elig;
   wire [1:0]   ctl_int;
   wire [7:0]   win_m;
   wire [7:0]   win_s;
   wire [15:0]  win;
   wire         disabled;

   integer      p;
   integer      c2;
   genvar       c;

   // lowest set bit, which is the highest priority with level 0 on top
   function [7:0] first_set;
      input [7:0] v;
      begin
         first_set = v & (~v + 8'h01);
      end
   endfunction

   // only these legacy inputs may take a pci line
   function route_ok;
      input [3:0] n;
      begin
         route_ok = (n >= 4'h3 && n <= 4'h7) || (n >= 4'h9 && n <= 4'hC) || (n >= 4'hE);
      end
   endfunction

   // one-hot to level; an empty winner returns the default level
   function [2:0] enc8;
      input [7:0] oh;
      integer i;
      begin
         enc8 = `DEFAULT_LEVEL;
         for (i = 0; i < 8; i = i + 1) begin
            if (oh[i])
               enc8 = i[2:0];
         end
      end
   endfunction

   assign disabled = (standby_state_in == `STANDBY_PARKED) ||
                     (standby_state_in == `STANDBY_OSC_OFF);

   // router and legacy line assembly
   always @* begin
      // serial-irq intx sources are active low and feed lines a-d directly
      pirq_n = {4'hF, serirq_intx_n_in};
      for (p = 0; p < 128; p = p + 1) begin
         if (pin_state_reg[p])
            pirq_n[device_pin_map_registers_in[p*`MAP_WIDTH +: `MAP_WIDTH]] = 1'b0;
      end
      routed = 16'h0000;
      for (p = 0; p < 8; p = p + 1) begin
         if (!pirq_route_in[p*`ROUTE_WIDTH + `ROUTE_DISABLE_BIT] &&
             route_ok(pirq_route_in[p*`ROUTE_WIDTH + `ROUTE_IRQ_LSB +: 4]))
            routed[pirq_route_in[p*`ROUTE_WIDTH + `ROUTE_IRQ_LSB +: 4]] =
               routed[pirq_route_in[p*`ROUTE_WIDTH + `ROUTE_IRQ_LSB +: 4]] | pirq_reg[p];
      end
      // an active-high serial source on a routed input would be ored in; software avoids that
      lines = serirq_irq_in | routed |
              {legacy_reg[3:2], 9'h000, legacy_reg[1:0], 3'h0};
   end

   // request, priority and masking per controller; 0 is master, 1 is slave
   generate
      for (c = 0; c < 2; c = c + 1) begin : ctl
         wire [7:0] in_service_bits    = isr_reg[c*8 +: 8];
         wire [7:0] tms    = trigger_mode_select_in[c*8 +: 8];
         wire [7:0] raw    = (tms & lines[c*8 +: 8]) | (~tms & edge_reg[c*8 +: 8]);
         wire [7:0] higher = (in_service_bits == 8'h00) ? 8'hFF : (first_set(in_service_bits) - 8'h01);
         if (c == 0) begin : mst
            // the cascade input follows the slave's request output
            assign irr[7:0] = {raw[7:3], ctl_int[1], raw[1:0]};
         end else begin : slv
            assign irr[15:8] = raw;
         end
         assign elig[c*8 +: 8] = irr[c*8 +: 8] & ~imr_reg[c*8 +: 8] &
                                 (smm_reg[c] ? ~in_service_bits : higher);
         assign ctl_int[c] = (|elig[c*8 +: 8]) & ~disabled;
      end
   endgenerate

   assign win_m = first_set(elig[7:0]);
   assign win_s = first_set(elig[15:8]) & {8{win_m[`CASCADE_BIT]}};
   assign win   = {win_s, win_m};

   // in-service and edge latch next state
   always @* begin
      ack_take = inta_in & ~disabled;
      // a new edge in the acknowledge cycle sets again: set wins over clear
      edge_next = (edge_reg & ~(ack_take ? win : 16'h0000)) | (lines & ~prev_reg);
      isr_next = ack_take ? (isr_reg | win) : isr_reg;
      cur = 8'h00;
      cand = 8'h00;
      clr = 8'h00;
      for (c2 = 0; c2 < 2; c2 = c2 + 1) begin
         cur = isr_next[c2*8 +: 8];
         cand = cur & (smm_reg[c2] ? ~imr_reg[c2*8 +: 8] : 8'hFF);
         clr = 8'h00;
         if (ack_take && auto_end_of_interrupt_reg[c2] && (win[c2*8 +: 8] != 8'h00))
            clr = first_set(cand);
         if (cmd_wr_in && (cmd_kind_in == `CMD_SECOND_OP) && (cmd_slave_in == c2[0])) begin
            case (cmd_data_in[`EOI_CMD_MSB:`EOI_CMD_LSB])
               `EOI_NONSPEC, `EOI_ROT_NONSPEC: begin
                  clr = clr | first_set(cand);
               end
               `EOI_SPEC, `EOI_ROT_SPEC: begin
                  clr = clr | (8'h01 << cmd_data_in[`EOI_LVL_MSB:`EOI_LVL_LSB]);
               end
               default: begin
                  clr = clr;
               end
            endcase
         end
         isr_next[c2*8 +: 8] = cur & ~clr;
      end
   end

   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_state_reg <= 128'h0;
         legacy_reg    <= 4'h0;
         imr_reg       <= `MASK_RESET;
         isr_reg       <= `ISR_RESET;
         edge_reg      <= 16'h0000;
         prev_reg      <= 16'h0000;
         smm_reg       <= `SMM_RESET;
         auto_end_of_interrupt_reg      <= `AUTO_END_OF_INTERRUPT_RESET;
         pirq_reg      <= 8'h00;
         ack_valid_out <= 1'b0;
         ack_irq_out   <= `ACK_IRQ_RESET;
      end else if (ce_in) begin
         pirq_reg      <= ~pirq_n;
         prev_reg      <= lines;
         edge_reg      <= edge_next;
         isr_reg       <= isr_next;
         ack_valid_out <= ack_take;
         if (ack_take) begin
            // a request that vanished before acknowledge returns the default level
            if (win_m[`CASCADE_BIT])
               ack_irq_out <= {1'b1, enc8(win_s)};
            else
               ack_irq_out <= {1'b0, enc8(win_m)};
         end
         if (msg_valid_in) begin
            if (msg_legacy_in)
               legacy_reg[msg_pin_in] <= msg_assert_in;
            else
               pin_state_reg[{msg_dev_in, msg_pin_in}] <= msg_assert_in;
         end
         if (cmd_wr_in) begin
            case (cmd_kind_in)
               `CMD_FIRST_OP: begin
                  imr_reg[{cmd_slave_in, 3'h0} +: 8] <= cmd_data_in;
               end
               `CMD_THIRD_OP: begin
                  if (cmd_data_in[`SPECIAL_MASK_WRITE_ENABLE_BIT])
                     smm_reg[cmd_slave_in] <= cmd_data_in[`SMM_BIT];
               end
               `CMD_FOURTH_INIT: begin
                  // the slave copy is kept but software leaves it clear
                  auto_end_of_interrupt_reg[cmd_slave_in] <= cmd_data_in[`AUTO_END_OF_INTERRUPT_BIT];
               end
               default: begin
                  smm_reg <= smm_reg;
               end
            endcase
         end
      end
   end

   assign intr_out                  = ctl_int[0];
   assign in_service_bits_out       = isr_reg;
   assign channel_mask_register_out = imr_reg;
   assign special_mask_out          = smm_reg;
   assign pci_interrupt_lines_out   = pirq_reg;

endmodule // pic_eoi_router

/* cpu_ack_model.sv */
// processor model that acknowledges pending interrupt requests
`timescale 1ns/1ps
module cpu_ack_model (
   // clock
   input  wire mclk_in,
   // control
   input  wire en_in,
   input  wire blind_in,
   input  wire intr_in,
   // acknowledge
   output reg  inta_out
);
   initial inta_out = 1'b0;
   // a gap after each pulse, so one request is never acknowledged twice
   always @(posedge mclk_in) begin
      inta_out <= en_in && (intr_in || blind_in) && !inta_out;
   end
endmodule // cpu_ack_model

/* pic_eoi_router_props.sv */
// concurrent checks on the ports of the interrupt router
`timescale 1ns/1ps
`include "pic_router_defines.vh"
module pic_eoi_router_props (
   input wire        mclk_in, rstn_in, ce_in, cmd_wr_in, cmd_slave_in, inta_in, intr_out, ack_valid_out,
   input wire [1:0]  cmd_kind_in, standby_state_in, special_mask_out,
   input wire [7:0]  cmd_data_in,
   input wire [15:0] in_service_bits_out, channel_mask_register_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   wire wr = ce_in && cmd_wr_in && !cmd_slave_in;
   wire deep = standby_state_in[1];
   wire [7:0] in_service_bits = in_service_bits_out[7:0];
   AST_STBY_INTR: assert property (deep |-> !intr_out) else $error("intr in standby");
   AST_STBY_ACK: assert property (ce_in && inta_in && deep |=> !ack_valid_out) else $error("ack in standby");
   AST_MASK: assert property (wr && cmd_kind_in == `CMD_FIRST_OP |=>
      channel_mask_register_out[7:0] == $past(cmd_data_in)) else $error("mask load");
   AST_ALLMASK: assert property (channel_mask_register_out[7:0] == 8'hFF |-> !intr_out)
      else $error("masked intr");
   AST_SMM_ON: assert property (wr && cmd_kind_in == `CMD_THIRD_OP && cmd_data_in[6:5] == 2'h3 |=>
      special_mask_out[0]) else $error("smm entry");
   AST_SMM_HOLD: assert property (ce_in && cmd_wr_in && cmd_kind_in == `CMD_THIRD_OP && !cmd_data_in[6] |=>
      $stable(special_mask_out)) else $error("smm hold");
   AST_SPEC: assert property (wr && cmd_kind_in == `CMD_SECOND_OP && cmd_data_in[7:5] == 3'h3 && !inta_in |=>
      !in_service_bits_out[$past(cmd_data_in[2:0])]) else $error("specific end");
   AST_NSPEC: assert property (wr && cmd_kind_in == `CMD_SECOND_OP && cmd_data_in[7:5] == 3'h1 && !inta_in
      && !special_mask_out[0] |=> in_service_bits == ($past(in_service_bits) & ($past(in_service_bits) - 8'h01))) else $error("nonspecific end");
endmodule // pic_eoi_router_props
bind pic_eoi_router pic_eoi_router_props u_props (.mclk_in, .rstn_in, .ce_in, .cmd_wr_in, .cmd_slave_in,
   .inta_in, .intr_out, .ack_valid_out, .cmd_kind_in, .standby_state_in, .special_mask_out, .cmd_data_in,
   .in_service_bits_out, .channel_mask_register_out);

/* testbench.sv */
// self-checking bench for the interrupt router and legacy controller pair
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
   reg          mclk_in = 0, rstn_in = 0, ce_in = 1, cmd_wr_in = 0, cmd_slave_in = 0, ack_en = 0, blind = 0;
   reg  [1:0]   cmd_kind_in = 0, standby_state_in = 0, msg_pin_in = 0;
   reg  [7:0]   cmd_data_in = 0, r;
   reg  [15:0]  trigger_mode_select_in = 0, serirq_irq_in = 0, exp_isr;
   reg  [383:0] device_pin_map_registers_in = 0;
   reg  [63:0]  pirq_route_in = {8{8'h80}};
   reg          msg_valid_in = 0, msg_legacy_in = 0, msg_assert_in = 0;
   reg  [4:0]   msg_dev_in = 0;
   reg  [3:0]   serirq_intx_n_in = 4'hF, irq;
   wire         inta_in, intr_out, ack_valid_out;
   wire [3:0]   ack_irq_out;
   wire [15:0]  in_service_bits_out, channel_mask_register_out;
   wire [1:0]   special_mask_out;
   wire [7:0]   pci_interrupt_lines_out;
   int          error_cnt = 0, tests_run = 0, i, d, p, k, s;
   logic [3:0]  legacy_irq [4] = '{4'h3, 4'h4, 4'hE, 4'hF};
   logic [3:0]  steer_irq [11] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
   pic_eoi_router uut (.mclk_in, .rstn_in, .ce_in, .cmd_wr_in, .cmd_slave_in, .cmd_kind_in, .cmd_data_in,
      .trigger_mode_select_in, .standby_state_in, .device_pin_map_registers_in, .pirq_route_in, .msg_valid_in,
      .msg_legacy_in, .msg_assert_in, .msg_dev_in, .msg_pin_in, .serirq_irq_in, .serirq_intx_n_in, .inta_in,
      .intr_out, .ack_valid_out, .ack_irq_out, .in_service_bits_out, .channel_mask_register_out,
      .special_mask_out, .pci_interrupt_lines_out);
   cpu_ack_model cpu (.mclk_in(mclk_in), .en_in(ack_en), .blind_in(blind), .intr_in(intr_out), .inta_out(inta_in));
   always #4 mclk_in = ~mclk_in;
   task test_done;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmd(input logic sl, input logic [1:0] kd, input logic [7:0] dt);
      @(posedge mclk_in);
      cmd_wr_in <= 1; cmd_slave_in <= sl; cmd_kind_in <= kd; cmd_data_in <= dt;
      @(posedge mclk_in);
      cmd_wr_in <= 0;
      #1;
   endtask
   task automatic msg(input logic lg, input logic as, input logic [4:0] dv, input logic [1:0] pn);
      @(posedge mclk_in);
      msg_valid_in <= 1; msg_legacy_in <= lg; msg_assert_in <= as; msg_dev_in <= dv; msg_pin_in <= pn;
      @(posedge mclk_in);
      msg_valid_in <= 0;
      #1;
   endtask
   // cascaded requests need the slave ended first, then the master
   task automatic eoi(input logic [3:0] n);
      if (n > 4'h7) cmd(1, 1, 8'h20);
      cmd(0, 1, 8'h20);
   endtask
   task automatic wait_ack(input logic [3:0] n);
      for (i = 0; i < 60 && ack_valid_out !== 1'b1; i++) @(posedge mclk_in) #1;
      if (i == 60) begin error_cnt++; test_done(); end
      `CHK("ack_irq", n, ack_irq_out)
   endtask
   initial begin
      s = $urandom(32'h621fbe72);
      repeat (10) @(posedge mclk_in);
      rstn_in <= 1;
      #1 `CHK("reset", 34'h0, {in_service_bits_out, channel_mask_register_out, special_mask_out})
      r = $urandom;
      cmd(0, 0, r);
      cmd(1, 0, ~r);
      `CHK("mask", {~r, r}, channel_mask_register_out)
      cmd(0, 0, 8'hFF);
      cmd(0, 0, 8'h00);
      cmd(1, 0, 8'h00);
      ack_en <= 1;
      for (p = 0; p < 4; p++) begin
         irq = legacy_irq[p];
         msg(1, 1, 0, p[1:0]);
         wait_ack(irq);
         exp_isr = (16'h1 << irq) | ((irq > 4'h7) ? 16'h4 : 16'h0);
         `CHK("isr", exp_isr, in_service_bits_out)
         eoi(irq);
         `CHK("isr", 16'h0, in_service_bits_out)
         msg(1, 0, 0, p[1:0]);
      end
      // a masked cascade input must hide a pending slave request until it is unmasked
      cmd(0, 0, 8'h04);
      msg(1, 1, 0, 2);
      repeat (5) @(posedge mclk_in);
      #1 `CHK("intr", 1'b0, intr_out)
      cmd(0, 0, 8'h00);
      wait_ack(4'hE);
      eoi(4'hE);
      `CHK("isr", 16'h0, in_service_bits_out)
      msg(1, 0, 0, 2);
      msg(1, 1, 0, 0);
      wait_ack(4'h3);
      msg(1, 1, 0, 1);
      repeat (5) @(posedge mclk_in);
      #1 `CHK("intr", 1'b0, intr_out)
      cmd(0, 2, 8'h60);
      `CHK("smm", 2'h1, special_mask_out)
      wait_ack(4'h4);
      cmd(0, 0, 8'h08);
      cmd(0, 1, 8'h20);
      `CHK("isr", 16'h0008, in_service_bits_out)
      cmd(0, 2, 8'h20);
      `CHK("smm", 2'h1, special_mask_out)
      cmd(0, 2, 8'h40);
      `CHK("smm", 2'h0, special_mask_out)
      cmd(0, 0, 8'h00);
      cmd(0, 1, 8'h63);
      `CHK("isr", 16'h0, in_service_bits_out)
      msg(1, 0, 0, 0);
      msg(1, 0, 0, 1);
      cmd(0, 3, 8'h02);
      msg(1, 1, 0, 1);
      wait_ack(4'h4);
      #8 `CHK("isr", 16'h0, in_service_bits_out)
      cmd(0, 3, 8'h00);
      msg(1, 0, 0, 1);
      d = $urandom_range(31);
      p = $urandom_range(3);
      k = $urandom_range(7);
      irq = steer_irq[$urandom_range(10)];
      device_pin_map_registers_in[(d * 4 + p) * 3 +: 3] <= k[2:0];
      pirq_route_in[8 * k +: 8] <= {4'h0, irq};
      trigger_mode_select_in[irq] <= 1'b1;
      msg(0, 1, d[4:0], p[1:0]);
      @(posedge mclk_in) #1 `CHK("pci", 8'h1 << k, pci_interrupt_lines_out)
      wait_ack(irq);
      msg(0, 0, d[4:0], p[1:0]);
      @(posedge mclk_in) #1 `CHK("pci", 8'h0, pci_interrupt_lines_out)
      eoi(irq);
      `CHK("isr", 16'h0, in_service_bits_out)
      standby_state_in <= 2'h2;
      blind <= 1;
      msg(1, 1, 0, 0);
      repeat (4) @(posedge mclk_in) #1 `CHK("standby", 2'h0, {intr_out, ack_valid_out})
      blind <= 0;
      standby_state_in <= 2'h0;
      wait_ack(4'h3);
      test_done();
   end
endmodule // testbench
